// File: pkg/psie_regs.svh
`ifndef PSIE_REGS_SVH
`define PSIE_REGS_SVH

`define PSIE_ADDR_W        12
`define PSIE_OFF_ENABLE    12'h300
`define PSIE_OFF_STATUS    12'h304
`define PSIE_OFF_ROUTE_A   12'h308
`define PSIE_OFF_ROUTE_B   12'h30c
`define PSIE_OFF_ROUTE_C   12'h310
`define PSIE_OFF_VEC_BASE  12'h320
`define PSIE_VEC_WIN_MASK  12'hfe0

`define PSIE_ENABLE_RST    32'h00000000
`define PSIE_STATUS_RST    32'h00000000
`define PSIE_ROUTE_RST     32'h00000000
`define PSIE_VEC_RST       8'h00

`define PSIE_ENABLE_MASK   32'h00fff7ff
`define PSIE_STATUS_MASK   32'h00fff7ff
`define PSIE_ROUTE_MASK    32'h77777777

`define PSIE_BIT_LM        20
`define PSIE_BIT_MBOX      16
`define PSIE_BIT_ACFAIL    15
`define PSIE_BIT_SYSFAIL   14
`define PSIE_BIT_SOFTWARE_INTERRUPT_ENABLE    13
`define PSIE_BIT_SOFTWARE_ACK_INTERRUPT_ENABLE   12
`define PSIE_BIT_VME_ERROR_INTERRUPT_ENABLE      10
`define PSIE_BIT_PCI_ERROR_INTERRUPT_ENABLE      9
`define PSIE_BIT_DMA       8
`define PSIE_BIT_VIRQ      1
`define PSIE_BIT_VME_OWNERSHIP_INTERRUPT_ENABLE      0

`define PSIE_ROUTED_SRC    24
`define PSIE_ROUTE_STRIDE  4
`define PSIE_SRC_PER_ROUTE 8

`define PSIE_PIN_ACFAIL    8
`define PSIE_PIN_SYSFAIL   7

`endif

// File: pkg/psie_pkg.sv
`default_nettype none

package psie_pkg;

  typedef enum logic {
    IACK_IDLE,
    IACK_WAIT
  } psie_iack_state_t;

  typedef struct packed {
    logic [31:0]       enable;
    logic [31:0]       status;
    logic [31:0]       route_a;
    logic [31:0]       route_b;
    logic [31:0]       route_c;
    logic [7:1][7:0]   vector;
    logic [2:0][8:0]   sync;
    logic [8:0]        pin_lvl;
    psie_iack_state_t  iack_state;
    logic              iack_req;
    logic [2:0]        iack_level;
    logic [31:0]       rdata;
    logic [7:0]        pci_int;
    logic              irq;
  } psie_state_t;

endpackage : psie_pkg

`default_nettype wire

// File: src/psie_route.sv
`timescale 1ns/1ps
`default_nettype none

module psie_route #(
  parameter int N_SRC = 32,
  parameter int N_OUT = 8,
  parameter int SEL_W = 3
) (
  input  wire logic [N_SRC-1:0]            active_in,
  input  wire logic [N_SRC-1:0][SEL_W-1:0] sel_in,
  output logic      [N_OUT-1:0]            route_out
);

  // Several sources may share one output; they are ORed
  always_comb begin
    route_out = '0;
    for (int s = 0; s < N_SRC; s++) begin
      for (int o = 0; o < N_OUT; o++) begin
        if (active_in[s] && (sel_in[s] == SEL_W'(o))) begin
          route_out[o] = 1'b1;
        end
      end
    end
  end

endmodule : psie_route

`default_nettype wire

// File: src/psie_top.sv
// What this block does
// - Enabled asserted level: request bus, run acknowledge
// - On completion store vector, set status, interrupt
// - No refetch at level while status set
// - Other enables gate their own sources
// - Enable 0-to-1 fires software interrupt; 0 masks
// - Monitor enables in bits 23:20
// - Mailbox enables in bits 19:16
// - Bits 15:12, 10:8 enables; 11 reserved
// - Bits 7:1 enable handler per level
// - Bit 0 ownership enable; 31:24 reserved
// - Status latches on event, write-one clears
// - Fail status latches; clear ignored while pin asserted
// - Three-bit field routes source to output
//
// Local design decision: the plain strobed port.
`include "psie_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module psie_top #(
  parameter int N_OUT = 8,
  parameter int SEL_W = 3
) (
  input  wire logic                    CLK_SYS_IN,
  input  wire logic                    SYS_RST_IN,
  input  wire logic [`PSIE_ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [31:0]             REG_WDATA_IN,
  input  wire logic                    REG_WR_IN,
  input  wire logic                    REG_RD_IN,
  output logic      [31:0]             REG_RDATA_OUT,
  input  wire logic [3:0]              LM_EVENT_IN,
  input  wire logic [3:0]              MBOX_EVENT_IN,
  input  wire logic                    SOFTWARE_ACK_INTERRUPT_ENABLE_EVENT_IN,
  input  wire logic                    VME_ERROR_INTERRUPT_ENABLE_EVENT_IN,
  input  wire logic                    PCI_ERROR_INTERRUPT_ENABLE_EVENT_IN,
  input  wire logic                    DMA_EVENT_IN,
  input  wire logic                    VME_OWNERSHIP_INTERRUPT_ENABLE_EVENT_IN,
  input  wire logic                    ACFAIL_N_IN,
  input  wire logic                    SYSFAIL_N_IN,
  input  wire logic [7:1]              VIRQ_N_IN,
  output logic                         IACK_REQ_OUT,
  output logic      [2:0]              IACK_LEVEL_OUT,
  input  wire logic                    IACK_DONE_IN,
  input  wire logic                    IACK_BERR_IN,
  input  wire logic [7:0]              IACK_VECTOR_IN,
  output logic      [N_OUT-1:0]        PCI_INT_OUT,
  output logic                         IRQ_OUT
);

  psie_pkg::psie_state_t cur_reg;
  psie_pkg::psie_state_t state_next;

  logic                          wr_enable;
  logic                          wr_status;
  logic                          wr_route_a;
  logic                          wr_route_b;
  logic                          wr_route_c;
  logic                          in_vec_win;
  logic [2:0]                    vec_idx;
  logic                          sw_rise;
  logic [31:0]                   events;
  logic [31:0]                   clr_bits;
  logic [31:0]                   active;
  logic [7:1]                    pending;
  logic [7:1]                    iack_set;
  logic [2:0][31:0]              route_group;
  logic [31:0][SEL_W-1:0]        route_sel;
  logic [N_OUT-1:0]              routed;

  assign wr_enable  = REG_WR_IN && (REG_ADDR_IN == `PSIE_OFF_ENABLE);
  assign wr_status  = REG_WR_IN && (REG_ADDR_IN == `PSIE_OFF_STATUS);
  assign wr_route_a = REG_WR_IN && (REG_ADDR_IN == `PSIE_OFF_ROUTE_A);
  assign wr_route_b = REG_WR_IN && (REG_ADDR_IN == `PSIE_OFF_ROUTE_B);
  assign wr_route_c = REG_WR_IN && (REG_ADDR_IN == `PSIE_OFF_ROUTE_C);
  assign in_vec_win = (REG_ADDR_IN & `PSIE_VEC_WIN_MASK) == `PSIE_OFF_VEC_BASE;
  assign vec_idx    = REG_ADDR_IN[4:2];

  // Only a written 1 over a stored 0 fires; rewriting 1 does nothing
  assign sw_rise = wr_enable && REG_WDATA_IN[`PSIE_BIT_SOFTWARE_INTERRUPT_ENABLE]
                   && !cur_reg.enable[`PSIE_BIT_SOFTWARE_INTERRUPT_ENABLE];

  // Write-one-to-clear mask from software
  assign clr_bits = wr_status ? (REG_WDATA_IN & `PSIE_STATUS_MASK) : 32'h00000000;

  // Levels wanting service: enabled, asserted, not already latched
  assign pending = cur_reg.enable[7:1]
                   & cur_reg.pin_lvl[6:0]
                   & ~cur_reg.status[7:1];

  // Drives outputs only with both status and enable set
  assign active = cur_reg.status & cur_reg.enable & `PSIE_STATUS_MASK;

  assign route_group = {cur_reg.route_c, cur_reg.route_b, cur_reg.route_a};

  // Field of source s sits in nibble s%8 of route register s/8
  for (genvar g = 0; g < 32; g++) begin : g_sel
    if (g < `PSIE_ROUTED_SRC) begin : g_used
      assign route_sel[g] =
        route_group[g / `PSIE_SRC_PER_ROUTE][(g % `PSIE_SRC_PER_ROUTE) * `PSIE_ROUTE_STRIDE +: SEL_W];
    end else begin : g_none
      assign route_sel[g] = '0;
    end
  end

  psie_route #(
    .N_SRC (32),
    .N_OUT (N_OUT),
    .SEL_W (SEL_W)
  ) u_route (
    .active_in (active),
    .sel_in    (route_sel),
    .route_out (routed)
  );

  always_comb begin
    state_next = cur_reg;
    iack_set   = '0;
    events     = 32'h00000000;

    // Three-stage pin synchroniser, inverted to active high on entry
    state_next.sync[0] = ~{ACFAIL_N_IN, SYSFAIL_N_IN, VIRQ_N_IN};
    state_next.sync[1] = cur_reg.sync[0];
    state_next.sync[2] = cur_reg.sync[1];
    for (int p = 0; p < 9; p++) begin
      if (cur_reg.sync[1][p] == cur_reg.sync[2][p]) begin
        state_next.pin_lvl[p] = cur_reg.sync[2][p];
      end
    end

    // Interrupt acknowledge handler
    case (cur_reg.iack_state)
      psie_pkg::IACK_IDLE: begin
        state_next.iack_req = 1'b0;
        if (|pending) begin
          // Ascending scan leaves the highest pending level
          for (int l = 1; l < 8; l++) begin
            if (pending[l]) begin
              state_next.iack_level = 3'(l);
            end
          end
          state_next.iack_req   = 1'b1;
          state_next.iack_state = psie_pkg::IACK_WAIT;
        end
      end
      psie_pkg::IACK_WAIT: begin
        if (IACK_DONE_IN) begin
          state_next.vector[cur_reg.iack_level] = IACK_VECTOR_IN;
          iack_set[cur_reg.iack_level]          = 1'b1;
          state_next.iack_req                   = 1'b0;
          state_next.iack_state                 = psie_pkg::IACK_IDLE;
        end else if (IACK_BERR_IN) begin
          // Failed cycle: nothing latched, level retried if still pending
          state_next.iack_req   = 1'b0;
          state_next.iack_state = psie_pkg::IACK_IDLE;
        end
      end
      default: begin
        state_next.iack_req   = 1'b0;
        state_next.iack_state = psie_pkg::IACK_IDLE;
      end
    endcase

    // Status events; fail bits are held while their pin stays asserted
    events[`PSIE_BIT_LM +: 4]    = LM_EVENT_IN;
    events[`PSIE_BIT_MBOX +: 4]  = MBOX_EVENT_IN;
    events[`PSIE_BIT_ACFAIL]     = cur_reg.pin_lvl[`PSIE_PIN_ACFAIL];
    events[`PSIE_BIT_SYSFAIL]    = cur_reg.pin_lvl[`PSIE_PIN_SYSFAIL];
    events[`PSIE_BIT_SOFTWARE_INTERRUPT_ENABLE]     = sw_rise;
    events[`PSIE_BIT_SOFTWARE_ACK_INTERRUPT_ENABLE]    = SOFTWARE_ACK_INTERRUPT_ENABLE_EVENT_IN;
    events[`PSIE_BIT_VME_ERROR_INTERRUPT_ENABLE]       = VME_ERROR_INTERRUPT_ENABLE_EVENT_IN;
    events[`PSIE_BIT_PCI_ERROR_INTERRUPT_ENABLE]       = PCI_ERROR_INTERRUPT_ENABLE_EVENT_IN;
    events[`PSIE_BIT_DMA]        = DMA_EVENT_IN;
    events[`PSIE_BIT_VIRQ +: 7]  = iack_set;
    events[`PSIE_BIT_VME_OWNERSHIP_INTERRUPT_ENABLE]       = VME_OWNERSHIP_INTERRUPT_ENABLE_EVENT_IN;

    // Set beats a clear in the same cycle so no event is lost
    state_next.status = ((cur_reg.status & ~clr_bits) | events) & `PSIE_STATUS_MASK;

    // Enable register; clearing software enable only masks
    if (wr_enable) begin
      state_next.enable = REG_WDATA_IN & `PSIE_ENABLE_MASK;
    end
    if (wr_route_a) begin
      state_next.route_a = REG_WDATA_IN & `PSIE_ROUTE_MASK;
    end
    if (wr_route_b) begin
      state_next.route_b = REG_WDATA_IN & `PSIE_ROUTE_MASK;
    end
    if (wr_route_c) begin
      state_next.route_c = REG_WDATA_IN & `PSIE_ROUTE_MASK;
    end

    // Read data stands for the one cycle after the strobe only
    state_next.rdata = 32'h00000000;
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == `PSIE_OFF_ENABLE) begin
        state_next.rdata = cur_reg.enable;
      end else if (REG_ADDR_IN == `PSIE_OFF_STATUS) begin
        state_next.rdata = cur_reg.status;
      end else if (REG_ADDR_IN == `PSIE_OFF_ROUTE_A) begin
        state_next.rdata = cur_reg.route_a;
      end else if (REG_ADDR_IN == `PSIE_OFF_ROUTE_B) begin
        state_next.rdata = cur_reg.route_b;
      end else if (REG_ADDR_IN == `PSIE_OFF_ROUTE_C) begin
        state_next.rdata = cur_reg.route_c;
      end else if (in_vec_win && (vec_idx != 3'h0)) begin
        state_next.rdata = {24'h000000, cur_reg.vector[vec_idx]};
      end
    end

    // Registered outputs lag the status by one cycle
    state_next.pci_int = routed;
    state_next.irq     = |active;
  end

  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cur_reg.enable     <= `PSIE_ENABLE_RST;
      cur_reg.status     <= `PSIE_STATUS_RST;
      cur_reg.route_a    <= `PSIE_ROUTE_RST;
      cur_reg.route_b    <= `PSIE_ROUTE_RST;
      cur_reg.route_c    <= `PSIE_ROUTE_RST;
      cur_reg.vector     <= {7{`PSIE_VEC_RST}};
      cur_reg.sync       <= '0;
      cur_reg.pin_lvl    <= '0;
      cur_reg.iack_state <= psie_pkg::IACK_IDLE;
      cur_reg.iack_req   <= 1'b0;
      cur_reg.iack_level <= 3'h0;
      cur_reg.rdata      <= 32'h00000000;
      cur_reg.pci_int    <= 8'h00;
      cur_reg.irq        <= 1'b0;
    end else begin
      cur_reg <= state_next;
    end
  end

  assign REG_RDATA_OUT  = cur_reg.rdata;
  assign IACK_REQ_OUT   = cur_reg.iack_req;
  assign IACK_LEVEL_OUT = cur_reg.iack_level;
  assign PCI_INT_OUT    = cur_reg.pci_int[N_OUT-1:0];
  assign IRQ_OUT        = cur_reg.irq;

endmodule : psie_top

`default_nettype wire

// File: test/psie_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psie_properties #(
  parameter int N_OUT = 8
) (
  input wire logic             CLK_SYS_IN,
  input wire logic             SYS_RST_IN,
  input wire logic [11:0]      REG_ADDR_IN,
  input wire logic             REG_RD_IN,
  input wire logic [31:0]      REG_RDATA_OUT,
  input wire logic             IACK_REQ_OUT,
  input wire logic [2:0]       IACK_LEVEL_OUT,
  input wire logic             IACK_DONE_IN,
  input wire logic             IACK_BERR_IN,
  input wire logic [N_OUT-1:0] PCI_INT_OUT,
  input wire logic             IRQ_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_done;
    IACK_REQ_OUT && IACK_DONE_IN;
  endsequence
  sequence s_end;
    IACK_REQ_OUT && (IACK_DONE_IN || IACK_BERR_IN);
  endsequence
  property p_rsv;
    REG_RD_IN && REG_ADDR_IN == 12'h300 |=> REG_RDATA_OUT[31:24] == 8'h00 && !REG_RDATA_OUT[11];
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved enable bits read nonzero");
  property p_hold;
    IACK_REQ_OUT && !IACK_DONE_IN && !IACK_BERR_IN |=> IACK_REQ_OUT && $stable(IACK_LEVEL_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("Acknowledge request not held");
  property p_drop;
    s_end |=> !IACK_REQ_OUT;
  endproperty
  a_drop: assert property (p_drop) else $error("Acknowledge request not dropped");
  property p_level;
    IACK_REQ_OUT |-> IACK_LEVEL_OUT != 3'h0;
  endproperty
  a_level: assert property (p_level) else $error("Acknowledge at level zero");
  property p_rst;
    $fell(SYS_RST_IN) |-> !IRQ_OUT && PCI_INT_OUT == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("Interrupt active after reset");
  property p_refetch;
    s_done |=> !IACK_REQ_OUT ##1 !(IACK_REQ_OUT && IACK_LEVEL_OUT == $past(IACK_LEVEL_OUT, 2));
  endproperty
  a_refetch: assert property (p_refetch) else $error("Level fetched again while pending");
  property p_route;
    (PCI_INT_OUT != '0) == IRQ_OUT;
  endproperty
  a_route: assert property (p_route) else $error("Routed outputs disagree with summary");
  property p_irq;
    s_done |-> ##[2:3] IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("No interrupt after acknowledge");
endmodule : psie_properties
bind psie_top psie_properties #(.N_OUT(N_OUT)) psie_properties_i (.CLK_SYS_IN, .SYS_RST_IN, .REG_ADDR_IN,
  .REG_RD_IN, .REG_RDATA_OUT, .IACK_REQ_OUT, .IACK_LEVEL_OUT, .IACK_DONE_IN, .IACK_BERR_IN, .PCI_INT_OUT,
  .IRQ_OUT);
`default_nettype wire

// File: test/psie_vme_model.sv
`timescale 1ns/1ps
`default_nettype none
module psie_vme_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       req_in,
  input  wire logic [2:0] level_in,
  input  wire logic [7:1] lines_in,
  input  wire logic [3:0] delay_in,
  output logic      [7:1] virq_n_out,
  output logic            done_out,
  output logic      [7:0] vector_out
);
  logic [3:0] wait_reg;
  logic [7:0] noise_reg;
  assign virq_n_out = ~lines_in;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_reg <= 4'h0;
      noise_reg <= 8'h00;
      done_out <= 1'b0;
      vector_out <= 8'h00;
    end else begin
      done_out <= 1'b0;
      noise_reg <= noise_reg + 8'h35;
      // Data lines float between answers, so never leave a stale vector
      vector_out <= noise_reg;
      wait_reg <= 4'h0;
      if (req_in && !done_out) begin
        if (wait_reg == delay_in) begin
          done_out <= 1'b1;
          vector_out <= {5'h14, level_in};
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule : psie_vme_model
`default_nettype wire

// File: test/psie_tb_top.sv
`include "psie_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module psie_tb_top;
  logic        clk, rst, wr, rd, iack_req, done, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, m;
  logic [23:0] ev;
  logic [1:0]  fail_n;
  logic [7:1]  lines, virq_n;
  logic [2:0]  level;
  logic [7:0]  vector, pci;
  logic [3:0]  dly;
  int          fail_count = 0;
  int          compares = 0;
  int          bits[15] = '{23, 22, 21, 20, 19, 18, 17, 16, 12, 10, 9, 8, 0, 15, 14};
  int          outs[15] = '{7, 6, 5, 4, 3, 2, 1, 0, 4, 3, 2, 1, 0, 7, 6};
  psie_top psie_top_i (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .LM_EVENT_IN(ev[23:20]), .MBOX_EVENT_IN(ev[19:16]),
    .SOFTWARE_ACK_INTERRUPT_ENABLE_EVENT_IN(ev[12]), .VME_ERROR_INTERRUPT_ENABLE_EVENT_IN(ev[10]), .PCI_ERROR_INTERRUPT_ENABLE_EVENT_IN(ev[9]), .DMA_EVENT_IN(ev[8]),
    .VME_OWNERSHIP_INTERRUPT_ENABLE_EVENT_IN(ev[0]), .ACFAIL_N_IN(fail_n[0]), .SYSFAIL_N_IN(fail_n[1]), .VIRQ_N_IN(virq_n),
    .IACK_REQ_OUT(iack_req), .IACK_LEVEL_OUT(level), .IACK_DONE_IN(done), .IACK_BERR_IN(1'b0),
    .IACK_VECTOR_IN(vector), .PCI_INT_OUT(pci), .IRQ_OUT(irq));
  psie_vme_model psie_vme_model_i (.clk_in(clk), .rst_in(rst), .req_in(iack_req), .level_in(level),
    .lines_in(lines), .delay_in(dly), .virq_n_out(virq_n), .done_out(done), .vector_out(vector));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %0s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, rdata);
  endtask : rd_chk
  task automatic wait_req();
    int n;
    n = 0;
    while (iack_req !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chk("iack request", 32'h1, {31'h0, iack_req});
  endtask : wait_req
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial begin
    rst = 1'b1; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; ev = '0; fail_n = 2'b11; lines = '0; dly = 4'h2;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (bits[i]) if (i < 6) rd_chk(12'h300 + 12'(4 * i), 32'h0);
    rd_chk(12'h3fc, 32'h0);
    wr_reg(`PSIE_OFF_ENABLE, 32'hffffffff);
    rd_chk(`PSIE_OFF_ENABLE, 32'h00fff7ff);
    wr_reg(`PSIE_OFF_ENABLE, 32'h0);
    // Writing all ones raised the software enable, so its status is latched
    rd_chk(`PSIE_OFF_STATUS, 32'h00002000);
    wr_reg(`PSIE_OFF_STATUS, 32'hffffffff);
    rd_chk(`PSIE_OFF_STATUS, 32'h0);
    wr_reg(`PSIE_OFF_ROUTE_A, 32'h76543210);
    wr_reg(`PSIE_OFF_ROUTE_B, 32'h76540321);
    wr_reg(`PSIE_OFF_ROUTE_C, 32'h76543210);
    for (int i = 0; i < 15; i++) begin
      m = 32'h1 << bits[i];
      if (i < 13) begin
        @(posedge clk);
        ev <= m[23:0];
        @(posedge clk);
        ev <= '0;
      end else fail_n[i-13] <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk(`PSIE_OFF_STATUS, m);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr_reg(`PSIE_OFF_ENABLE, m);
      repeat (3) @(posedge clk);
      #1 chk("routed output", 32'h1 << outs[i], {24'h0, pci});
      chk("irq raised", 32'h1, {31'h0, irq});
      wr_reg(`PSIE_OFF_STATUS, m);
      rd_chk(`PSIE_OFF_STATUS, (i < 13) ? 32'h0 : m);
      if (i >= 13) begin
        fail_n <= 2'b11;
        repeat (6) @(posedge clk);
        wr_reg(`PSIE_OFF_STATUS, m);
        rd_chk(`PSIE_OFF_STATUS, 32'h0);
      end
      chk("output cleared", 32'h0, {24'h0, pci});
      wr_reg(`PSIE_OFF_ENABLE, 32'h0);
    end
    wr_reg(`PSIE_OFF_ENABLE, 32'h2000);
    repeat (3) @(posedge clk);
    #1 chk("software int", 32'h20, {24'h0, pci});
    wr_reg(`PSIE_OFF_ENABLE, 32'h0);
    rd_chk(`PSIE_OFF_STATUS, 32'h2000);
    chk("software masked", 32'h0, {24'h0, pci});
    wr_reg(`PSIE_OFF_STATUS, 32'h2000);
    wr_reg(`PSIE_OFF_ENABLE, 32'hf8);
    lines <= 7'b0010110;
    wait_req();
    chk("iack level", 32'h5, {29'h0, level});
    repeat (20) @(posedge clk);
    rd_chk(`PSIE_OFF_STATUS, 32'h28);
    chk("level outputs", 32'h28, {24'h0, pci});
    rd_chk(12'h334, 32'ha5);
    rd_chk(12'h32c, 32'ha3);
    chk("no refetch", 32'h0, {31'h0, iack_req});
    dly <= 4'h9;
    wr_reg(`PSIE_OFF_STATUS, 32'h20);
    wait_req();
    chk("refetch level", 32'h5, {29'h0, level});
    repeat (20) @(posedge clk);
    rd_chk(`PSIE_OFF_STATUS, 32'h28);
    // Second reset mid-run, with levels still asserted and status latched
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`PSIE_OFF_ENABLE, 32'h0);
    rd_chk(`PSIE_OFF_STATUS, 32'h0);
    rd_chk(`PSIE_OFF_ROUTE_A, 32'h0);
    rd_chk(12'h334, 32'h0);
    chk("outputs after reset", 32'h0, {23'h0, irq, pci});
    repeat (6) @(posedge clk);
    chk("no fetch after reset", 32'h0, {31'h0, iack_req});
    lines <= '0;
    print_verdict();
  end
endmodule : psie_tb_top
`default_nettype wire
